// ---- hw/aie_params.svh ----
// constants for the add and and execution datapath
`ifndef AIE_PARAMS_SVH
`define AIE_PARAMS_SVH
`define AIE_DATA_W      8
`define AIE_HALF_BIT    3
`define AIE_SIGN_BIT    7
`define AIE_BYTE_RST    8'h00
`define AIE_FLAG_RST    1'b0
`define AIE_ZERO_BYTE   8'h00
`endif

// ---- hw/aie_pkg.sv ----
// types shared by the execution datapath modules
`include "aie_params.svh"
package aie_pkg;
    // instruction classes presented by the decoder
    typedef enum logic [3:0] {
        AIE_OP_NOP,
        AIE_OP_ADC_ACC,
        AIE_OP_SUM_WITH_CARRY_INTO_MEMORY,
        AIE_OP_ADD_MEM_ACC,
        AIE_OP_ADD_IMM,
        AIE_OP_SUM_INTO_MEMORY,
        AIE_OP_AND_MEM_ACC,
        AIE_OP_AND_IMM,
        AIE_OP_CONJUNCTION_INTO_MEMORY,
        AIE_OP_SKIP,
        AIE_OP_WATCHDOG_PRECLEAR_FIRST,
        AIE_OP_WATCHDOG_PRECLEAR_SECOND,
        AIE_OP_OTHER
    } aie_op_t;

    // which pre-clear instruction ran last
    typedef enum logic [1:0] {
        AIE_PRE_NONE,
        AIE_PRE_FIRST,
        AIE_PRE_SECOND
    } aie_pre_t;

    // whole state of the execution unit
    typedef struct packed {
        logic [`AIE_DATA_W-1:0] work_register;
        logic                   carry;
        logic                   half_carry;
        logic                   signed_range_error;
        logic                   zero_flag;
        logic                   watchdog_expired_flag;
        logic                   sleep_entered_flag;
        aie_pre_t               last_pre;
        logic                   stall;
        logic                   done;
        logic                   mem_wr_en;
        logic [`AIE_DATA_W-1:0] mem_wr_data;
        logic                   wdt_clear;
    } aie_state_t;
endpackage

// ---- hw/aie_alu_if.sv ----
// operand and result bundle between the sequencer and the arithmetic unit
`include "aie_params.svh"
interface aie_alu_if;
    logic [`AIE_DATA_W-1:0] opa;
    logic [`AIE_DATA_W-1:0] opb;
    logic                   cin;
    logic [`AIE_DATA_W-1:0] sum;
    logic [`AIE_DATA_W-1:0] conj;
    logic                   cout;
    logic                   hout;
    logic                   vout;
    modport exec (output opa, opb, cin, input sum, conj, cout, hout, vout);
    modport alu  (input opa, opb, cin, output sum, conj, cout, hout, vout);
endinterface

// ---- hw/aie_alu.sv ----
// adder and and unit with carry, half-carry and overflow outputs
`include "aie_params.svh"
module aie_alu (
    aie_alu_if.alu port_io
);
    import aie_pkg::*;

    logic [`AIE_DATA_W:0]     full_sum;
    logic [`AIE_HALF_BIT+1:0] low_sum;

    // 9-bit and 5-bit sums give bit 7 and bit 3 carries
    always_comb begin
        full_sum = {1'b0, port_io.opa} + {1'b0, port_io.opb}
                   + {{`AIE_DATA_W{1'b0}}, port_io.cin};
        low_sum  = {1'b0, port_io.opa[`AIE_HALF_BIT:0]} + {1'b0, port_io.opb[`AIE_HALF_BIT:0]}
                   + {{(`AIE_HALF_BIT+1){1'b0}}, port_io.cin};
    end

    // result and flag outputs
    assign port_io.sum  = full_sum[`AIE_DATA_W-1:0];
    assign port_io.cout = full_sum[`AIE_DATA_W];
    assign port_io.hout = low_sum[`AIE_HALF_BIT+1];
    assign port_io.vout = (port_io.opa[`AIE_SIGN_BIT] == port_io.opb[`AIE_SIGN_BIT])
                          && (full_sum[`AIE_SIGN_BIT] != port_io.opa[`AIE_SIGN_BIT]);
    assign port_io.conj = port_io.opa & port_io.opb;
endmodule

// ---- hw/aie_exec.sv ----
// execution unit for add, add with carry, and, skip timing and watchdog pre-clear
// Operation
// - a skip takes two cycles when it skips, one when it does not
// - any instruction writing the program counter low byte takes two cycles
// - both pre-clear instructions in succession clear watchdog and sleep flags
// - add with carry to work register updates overflow, zero, half-carry, carry
// - add with carry into memory writes sum back and updates the four flags
// - add from memory into work register, no carry in, four flags updated
// - add immediate into work register, no carry in, four flags updated
// - add into memory writes work register plus byte back, four flags updated
// - and from memory into work register, only zero flag updated
// - and immediate into work register, only zero flag updated
// - and into memory writes result back, only zero flag updated
// - repeating the first pre-clear without the second has no effect
`include "aie_params.svh"
module aie_exec (
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire logic                   op_valid,
    output logic                        op_ready,
    input  wire aie_pkg::aie_op_t       op_kind,
    input  wire logic [`AIE_DATA_W-1:0] op_mem_data,
    input  wire logic [`AIE_DATA_W-1:0] op_imm,
    input  wire logic                   op_skip,
    input  wire logic                   op_pcl_write,
    output logic                        op_done,
    output logic                        mem_wr_en,
    output logic [`AIE_DATA_W-1:0]      mem_wr_data,
    output logic [`AIE_DATA_W-1:0]      work_register,
    output logic                        carry,
    output logic                        half_carry,
    output logic                        signed_range_error,
    output logic                        zero_flag,
    input  wire logic                   watchdog_expire_evt,
    input  wire logic                   sleep_enter_evt,
    output logic                        watchdog_expired_flag,
    output logic                        sleep_entered_flag,
    output logic                        wdt_clear
);
    import aie_pkg::*;

    aie_state_t st;
    aie_state_t next_st;
    aie_alu_if  alu_bus ();
    logic       take;
    logic       two_cycle;

    aie_alu u_alu (
        .port_io (alu_bus.alu)
    );

    // handshake and instruction length
    assign op_ready  = !st.stall;
    assign take      = op_valid && op_ready;
    assign two_cycle = op_pcl_write || (op_kind == AIE_OP_SKIP && op_skip);

    // operand selection for the arithmetic unit
    always_comb begin
        alu_bus.opa = st.work_register;
        alu_bus.opb = (op_kind == AIE_OP_ADD_IMM || op_kind == AIE_OP_AND_IMM) ? op_imm
                      : op_mem_data;
        alu_bus.cin = (op_kind == AIE_OP_ADC_ACC
                       || op_kind == AIE_OP_SUM_WITH_CARRY_INTO_MEMORY) ? st.carry : 1'b0;
    end

    // next state
    always_comb begin
        next_st           = st;
        next_st.done      = 1'b0;
        next_st.mem_wr_en = 1'b0;
        next_st.wdt_clear = 1'b0;
        if (st.stall) begin
            next_st.stall = 1'b0; // second machine cycle ends here
            next_st.done  = 1'b1;
        end else if (take) begin
            next_st.stall = two_cycle;
            next_st.done  = !two_cycle;
            if (op_kind != AIE_OP_WATCHDOG_PRECLEAR_FIRST
                && op_kind != AIE_OP_WATCHDOG_PRECLEAR_SECOND) begin
                next_st.last_pre = AIE_PRE_NONE; // anything else breaks the pair
            end
            case (op_kind)
                AIE_OP_ADC_ACC, AIE_OP_ADD_MEM_ACC, AIE_OP_ADD_IMM: begin
                    next_st.work_register = alu_bus.sum;
                end
                AIE_OP_SUM_WITH_CARRY_INTO_MEMORY, AIE_OP_SUM_INTO_MEMORY: begin
                    next_st.mem_wr_en   = 1'b1;
                    next_st.mem_wr_data = alu_bus.sum;
                end
                AIE_OP_AND_MEM_ACC, AIE_OP_AND_IMM: begin
                    next_st.work_register = alu_bus.conj;
                    next_st.zero_flag     = (alu_bus.conj == `AIE_ZERO_BYTE);
                end
                AIE_OP_CONJUNCTION_INTO_MEMORY: begin
                    next_st.mem_wr_en   = 1'b1;
                    next_st.mem_wr_data = alu_bus.conj;
                    next_st.zero_flag   = (alu_bus.conj == `AIE_ZERO_BYTE);
                end
                AIE_OP_WATCHDOG_PRECLEAR_FIRST: begin
                    if (st.last_pre == AIE_PRE_SECOND) begin
                        next_st.last_pre              = AIE_PRE_NONE;
                        next_st.watchdog_expired_flag = `AIE_FLAG_RST;
                        next_st.sleep_entered_flag    = `AIE_FLAG_RST;
                        next_st.wdt_clear             = 1'b1;
                    end else begin
                        next_st.last_pre = AIE_PRE_FIRST;
                    end
                end
                AIE_OP_WATCHDOG_PRECLEAR_SECOND: begin
                    if (st.last_pre == AIE_PRE_FIRST) begin
                        next_st.last_pre              = AIE_PRE_NONE;
                        next_st.watchdog_expired_flag = `AIE_FLAG_RST;
                        next_st.sleep_entered_flag    = `AIE_FLAG_RST;
                        next_st.wdt_clear             = 1'b1;
                    end else begin
                        next_st.last_pre = AIE_PRE_SECOND;
                    end
                end
                default: begin
                end
            endcase
            // every add form updates all four arithmetic flags
            if (op_kind == AIE_OP_ADC_ACC || op_kind == AIE_OP_ADD_MEM_ACC
                || op_kind == AIE_OP_ADD_IMM || op_kind == AIE_OP_SUM_INTO_MEMORY
                || op_kind == AIE_OP_SUM_WITH_CARRY_INTO_MEMORY) begin
                next_st.carry              = alu_bus.cout;
                next_st.half_carry         = alu_bus.hout;
                next_st.signed_range_error = alu_bus.vout;
                next_st.zero_flag          = (alu_bus.sum == `AIE_ZERO_BYTE);
            end
        end
        // a new expiry or sleep entry beats a clear in the same cycle
        if (watchdog_expire_evt) begin
            next_st.watchdog_expired_flag = 1'b1;
        end
        if (sleep_enter_evt) begin
            next_st.sleep_entered_flag = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            next_st_reset: begin
                st.work_register         <= `AIE_BYTE_RST;
                st.carry                 <= `AIE_FLAG_RST;
                st.half_carry            <= `AIE_FLAG_RST;
                st.signed_range_error    <= `AIE_FLAG_RST;
                st.zero_flag             <= `AIE_FLAG_RST;
                st.watchdog_expired_flag <= `AIE_FLAG_RST;
                st.sleep_entered_flag    <= `AIE_FLAG_RST;
                st.last_pre              <= AIE_PRE_NONE;
                st.stall                 <= 1'b0;
                st.done                  <= 1'b0;
                st.mem_wr_en             <= 1'b0;
                st.mem_wr_data           <= `AIE_BYTE_RST;
                st.wdt_clear             <= 1'b0;
            end
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign op_done               = st.done;
    assign mem_wr_en             = st.mem_wr_en;
    assign mem_wr_data           = st.mem_wr_data;
    assign work_register         = st.work_register;
    assign carry                 = st.carry;
    assign half_carry            = st.half_carry;
    assign signed_range_error    = st.signed_range_error;
    assign zero_flag             = st.zero_flag;
    assign watchdog_expired_flag = st.watchdog_expired_flag;
    assign sleep_entered_flag    = st.sleep_entered_flag;
    assign wdt_clear             = st.wdt_clear;

    // reference sums for the checks below
    logic [`AIE_DATA_W:0]     chk_cs;
    logic [`AIE_DATA_W:0]     chk_ns;
    logic [`AIE_DATA_W:0]     chk_is;
    logic [`AIE_HALF_BIT+1:0] chk_h;
    logic [`AIE_DATA_W-1:0]   chk_an;
    always_comb begin
        chk_cs = {1'b0, st.work_register} + {1'b0, op_mem_data}
                 + {{`AIE_DATA_W{1'b0}}, st.carry};
        chk_ns = {1'b0, st.work_register} + {1'b0, op_mem_data};
        chk_is = {1'b0, st.work_register} + {1'b0, op_imm};
        chk_h  = {1'b0, st.work_register[`AIE_HALF_BIT:0]} + {1'b0, op_mem_data[`AIE_HALF_BIT:0]};
        chk_an = st.work_register & op_mem_data;
    end

    a_skip_two_cycles: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_SKIP && op_skip |=> !op_ready && !op_done ##1 op_done)
        else $error("taken skip did not last two cycles");
    a_noskip_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_SKIP && !op_skip && !op_pcl_write |=> op_done && op_ready)
        else $error("untaken skip did not last one cycle");
    a_pcl_two_cycles: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_pcl_write |=> !op_ready ##1 (op_done && op_ready))
        else $error("low byte write did not last two cycles");
    a_preclear_pair_clears: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_WATCHDOG_PRECLEAR_SECOND && st.last_pre == AIE_PRE_FIRST
        && !watchdog_expire_evt && !sleep_enter_evt
        |=> !watchdog_expired_flag && !sleep_entered_flag && wdt_clear)
        else $error("pre-clear pair did not clear flags");
    a_preclear_repeat_idle: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_WATCHDOG_PRECLEAR_FIRST && st.last_pre != AIE_PRE_SECOND
        && !watchdog_expire_evt && !sleep_enter_evt
        |=> $stable(watchdog_expired_flag) && $stable(sleep_entered_flag) && !wdt_clear)
        else $error("lone first pre-clear changed flags");
    a_adc_acc_sum: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_ADC_ACC
        |=> work_register == $past(chk_cs[`AIE_DATA_W-1:0]) && carry == $past(chk_cs[`AIE_DATA_W]))
        else $error("add with carry to work register wrong");
    a_adc_mem_sum: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_SUM_WITH_CARRY_INTO_MEMORY
        |=> mem_wr_en && mem_wr_data == $past(chk_cs[`AIE_DATA_W-1:0]) && $stable(work_register))
        else $error("add with carry into memory wrong");
    a_add_mem_half: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_ADD_MEM_ACC
        |=> work_register == $past(chk_ns[`AIE_DATA_W-1:0])
            && half_carry == $past(chk_h[`AIE_HALF_BIT+1])
            && zero_flag == (work_register == `AIE_ZERO_BYTE))
        else $error("add from memory wrong");
    a_add_imm_sum: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_ADD_IMM
        |=> work_register == $past(chk_is[`AIE_DATA_W-1:0]) && carry == $past(chk_is[`AIE_DATA_W]))
        else $error("add immediate wrong");
    a_add_into_mem: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_SUM_INTO_MEMORY
        |=> mem_wr_en && mem_wr_data == $past(chk_ns[`AIE_DATA_W-1:0]))
        else $error("add into memory wrong");
    a_and_keeps_carry: assert property (@(posedge clk_sys) disable iff (srst)
        take && (op_kind == AIE_OP_AND_MEM_ACC || op_kind == AIE_OP_AND_IMM)
        |=> $stable(carry) && $stable(half_carry) && $stable(signed_range_error)
            && zero_flag == (work_register == `AIE_ZERO_BYTE))
        else $error("and touched other flags");
    a_and_into_mem: assert property (@(posedge clk_sys) disable iff (srst)
        take && op_kind == AIE_OP_CONJUNCTION_INTO_MEMORY
        |=> mem_wr_en && mem_wr_data == $past(chk_an) && $stable(carry))
        else $error("and into memory wrong");
endmodule

// ---- verif/aie_mem_model.sv ----
// data memory model that feeds operand bytes and takes write-backs
module aie_mem_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] addr,
    input  wire logic       load_en,
    input  wire logic [7:0] load_data,
    input  wire logic       op_valid,
    input  wire logic       op_ready,
    input  wire logic       mem_wr_en,
    input  wire logic [7:0] mem_wr_data,
    output logic      [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [3:0] wr_addr;
    // preload, remember the address at the take, write back on the pulse
    always_ff @(posedge clk_sys) begin
        if (load_en) mem[addr] <= load_data;
        if (op_valid && op_ready) wr_addr <= addr;
        if (mem_wr_en) mem[wr_addr] <= mem_wr_data;
    end
    // no byte is presented without a request: show a changed value then
    assign rd_data = op_valid ? mem[addr] : ~mem[addr];
endmodule

// ---- verif/aie_exec_tb.sv ----
// self-checking bench for the add and and execution unit
`include "aie_params.svh"
module aie_exec_tb
    import aie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        aie_op_t    op;
        logic [7:0] mem, imm, acc;
        logic [3:0] flg;
        logic       wr;
        logic [7:0] wd;
    } aie_row_t;
    // operation, memory byte, immediate, then work register, flags chvz, write
    aie_row_t rows [17] = '{
        '{AIE_OP_ADD_IMM, 8'h00, 8'h0F, 8'h0F, 4'h0, 1'b0, 8'h00},
        '{AIE_OP_ADD_IMM, 8'h00, 8'h01, 8'h10, 4'h4, 1'b0, 8'h00},
        '{AIE_OP_ADD_MEM_ACC, 8'h70, 8'h00, 8'h80, 4'h2, 1'b0, 8'h00},
        '{AIE_OP_ADD_MEM_ACC, 8'h80, 8'h00, 8'h00, 4'hB, 1'b0, 8'h00},
        '{AIE_OP_ADC_ACC, 8'h00, 8'h00, 8'h01, 4'h0, 1'b0, 8'h00},
        '{AIE_OP_ADD_IMM, 8'h00, 8'hFF, 8'h00, 4'hD, 1'b0, 8'h00},
        '{AIE_OP_SUM_WITH_CARRY_INTO_MEMORY, 8'h7F, 8'h00, 8'h00, 4'h6, 1'b1, 8'h80},
        '{AIE_OP_ADD_IMM, 8'h00, 8'hFF, 8'hFF, 4'h0, 1'b0, 8'h00},
        '{AIE_OP_ADD_IMM, 8'h00, 8'h01, 8'h00, 4'hD, 1'b0, 8'h00},
        '{AIE_OP_SUM_INTO_MEMORY, 8'h05, 8'h00, 8'h00, 4'h0, 1'b1, 8'h05},
        '{AIE_OP_ADD_IMM, 8'h00, 8'hFF, 8'hFF, 4'h0, 1'b0, 8'h00},
        '{AIE_OP_ADD_IMM, 8'h00, 8'hF6, 8'hF5, 4'hC, 1'b0, 8'h00},
        '{AIE_OP_AND_IMM, 8'h00, 8'h3C, 8'h34, 4'hC, 1'b0, 8'h00},
        '{AIE_OP_CONJUNCTION_INTO_MEMORY, 8'h0B, 8'h00, 8'h34, 4'hD, 1'b1, 8'h00},
        '{AIE_OP_AND_MEM_ACC, 8'h24, 8'h00, 8'h24, 4'hC, 1'b0, 8'h00},
        '{AIE_OP_ADC_ACC, 8'hDB, 8'h00, 8'h00, 4'hD, 1'b0, 8'h00},
        '{AIE_OP_ADD_MEM_ACC, 8'h01, 8'h00, 8'h01, 4'h0, 1'b0, 8'h00}
    };
    aie_op_t wd_ops [7] = '{AIE_OP_WATCHDOG_PRECLEAR_FIRST, AIE_OP_WATCHDOG_PRECLEAR_FIRST,
        AIE_OP_NOP, AIE_OP_WATCHDOG_PRECLEAR_SECOND, AIE_OP_NOP,
        AIE_OP_WATCHDOG_PRECLEAR_FIRST, AIE_OP_WATCHDOG_PRECLEAR_SECOND};
    logic                   wd_clr [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic                   clk_sys, srst, op_valid, op_skip, op_pcl_write, load_en;
    logic                   watchdog_expire_evt, sleep_enter_evt;
    aie_op_t                op_kind;
    logic [`AIE_DATA_W-1:0] op_imm, op_mem_data, load_data, mem_wr_data, work_register;
    logic [3:0]             addr, flg;
    logic                   op_ready, op_done, mem_wr_en, carry, half_carry;
    logic                   signed_range_error, zero_flag, wdt_clear;
    logic                   watchdog_expired_flag, sleep_entered_flag;
    logic                   row_ok;
    int                     mismatches = 0, comparisons = 0, cycles = 0, i;
    assign flg = {carry, half_carry, signed_range_error, zero_flag};

    aie_exec i_dut (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid), .op_ready(op_ready),
        .op_kind(op_kind), .op_mem_data(op_mem_data), .op_imm(op_imm), .op_skip(op_skip),
        .op_pcl_write(op_pcl_write), .op_done(op_done), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .work_register(work_register), .carry(carry),
        .half_carry(half_carry), .signed_range_error(signed_range_error),
        .zero_flag(zero_flag), .watchdog_expire_evt(watchdog_expire_evt),
        .sleep_enter_evt(sleep_enter_evt), .watchdog_expired_flag(watchdog_expired_flag),
        .sleep_entered_flag(sleep_entered_flag), .wdt_clear(wdt_clear));
    aie_mem_model i_mem (.clk_sys(clk_sys), .addr(addr), .load_en(load_en),
        .load_data(load_data), .op_valid(op_valid), .op_ready(op_ready),
        .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .rd_data(op_mem_data));

    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            give_verdict();
        end
    end

    // comparison, request and closing helpers
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic issue(input aie_op_t k, input logic [7:0] imm, input logic skp, program_counter_low_byte);
        op_valid = 1'b1;
        op_kind = k;
        op_imm = imm;
        op_skip = skp;
        op_pcl_write = program_counter_low_byte;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {srst, load_en} = 2'b10;
        {watchdog_expire_evt, sleep_enter_evt} = 2'b00;
        {op_valid, op_skip, op_pcl_write} = 3'b000;
        op_kind = AIE_OP_NOP;
        op_imm = 8'h00;
        {addr, load_data} = 12'h000;
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        chk(work_register === 8'h00 && flg === 4'h0 && op_ready === 1'b1 && op_done === 1'b0
            && mem_wr_en === 1'b0 && wdt_clear === 1'b0 && watchdog_expired_flag === 1'b0
            && sleep_entered_flag === 1'b0, "reset values");
        $display("test reset done");
        for (i = 0; i < 17; i++) begin
            {load_en, addr, load_data} = {1'b1, i[3:0], rows[i].mem};
            @(negedge clk_sys);
        end
        load_en = 1'b0;
        for (i = 0; i <= 17; i++) begin
            if (i > 0) begin
                row_ok = op_done === 1'b1 && work_register === rows[i-1].acc
                         && flg === rows[i-1].flg && mem_wr_en === rows[i-1].wr
                         && (!rows[i-1].wr || mem_wr_data === rows[i-1].wd);
                chk(row_ok, "table row");
            end
            if (i < 17) begin
                issue(rows[i].op, rows[i].imm, 1'b0, 1'b0);
                addr = i[3:0];
            end else op_valid = 1'b0;
            @(negedge clk_sys);
        end
        $display("test table done");
        issue(AIE_OP_SKIP, 8'h00, 1'b1, 1'b0);
        @(negedge clk_sys);
        chk(op_ready === 1'b0 && op_done === 1'b0, "taken skip stall");
        issue(AIE_OP_ADD_IMM, 8'h01, 1'b0, 1'b0);
        @(negedge clk_sys);
        chk(op_done === 1'b1 && op_ready === 1'b1 && work_register === 8'h01, "skip end");
        @(negedge clk_sys);
        op_valid = 1'b0;
        chk(op_done === 1'b1 && work_register === 8'h02, "held add taken");
        @(negedge clk_sys);
        chk(op_done === 1'b0 && work_register === 8'h02, "held add taken twice");
        issue(AIE_OP_SKIP, 8'h00, 1'b0, 1'b0);
        @(negedge clk_sys);
        chk(op_done === 1'b1 && op_ready === 1'b1, "untaken skip");
        issue(AIE_OP_OTHER, 8'h00, 1'b0, 1'b1);
        @(negedge clk_sys);
        op_valid = 1'b0;
        chk(op_ready === 1'b0 && op_done === 1'b0, "pcl write stall");
        @(negedge clk_sys);
        chk(op_done === 1'b1 && op_ready === 1'b1, "pcl write end");
        $display("test cycle counts done");
        {watchdog_expire_evt, sleep_enter_evt} = 2'b11;
        @(negedge clk_sys);
        {watchdog_expire_evt, sleep_enter_evt} = 2'b00;
        @(negedge clk_sys);
        chk(watchdog_expired_flag === 1'b1 && sleep_entered_flag === 1'b1, "flag set");
        for (i = 0; i <= 7; i++) begin
            if (i > 0) begin
                row_ok = watchdog_expired_flag === !wd_clr[i-1]
                         && sleep_entered_flag === !wd_clr[i-1] && wdt_clear === wd_clr[i-1];
                chk(row_ok, "pre-clear pairing");
            end
            if (i < 7) issue(wd_ops[i], 8'h00, 1'b0, 1'b0);
            else op_valid = 1'b0;
            @(negedge clk_sys);
        end
        $display("test pre-clear done");
        // second then first pairs too, and a set event beats the pair's clear
        {watchdog_expire_evt, sleep_enter_evt} = 2'b11;
        @(negedge clk_sys);
        {watchdog_expire_evt, sleep_enter_evt} = 2'b00;
        issue(AIE_OP_WATCHDOG_PRECLEAR_SECOND, 8'h00, 1'b0, 1'b0);
        @(negedge clk_sys);
        issue(AIE_OP_WATCHDOG_PRECLEAR_FIRST, 8'h00, 1'b0, 1'b0);
        @(negedge clk_sys);
        row_ok = watchdog_expired_flag === 1'b0 && sleep_entered_flag === 1'b0
                 && wdt_clear === 1'b1;
        chk(row_ok, "reverse pre-clear pair");
        issue(AIE_OP_WATCHDOG_PRECLEAR_FIRST, 8'h00, 1'b0, 1'b0);
        @(negedge clk_sys);
        issue(AIE_OP_WATCHDOG_PRECLEAR_SECOND, 8'h00, 1'b0, 1'b0);
        {watchdog_expire_evt, sleep_enter_evt} = 2'b11;
        @(negedge clk_sys);
        op_valid = 1'b0;
        {watchdog_expire_evt, sleep_enter_evt} = 2'b00;
        row_ok = watchdog_expired_flag === 1'b1 && sleep_entered_flag === 1'b1
                 && wdt_clear === 1'b1;
        chk(row_ok, "set event beats pair clear");
        $display("test pre-clear order done");
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        row_ok = work_register === 8'h00 && flg === 4'h0 && op_done === 1'b0
                 && watchdog_expired_flag === 1'b0 && sleep_entered_flag === 1'b0;
        chk(row_ok, "mid-run reset");
        srst = 1'b0;
        issue(AIE_OP_ADD_IMM, 8'h05, 1'b0, 1'b0);
        @(negedge clk_sys);
        op_valid = 1'b0;
        chk(op_done === 1'b1 && work_register === 8'h05, "first take after reset");
        $display("test second reset done");
        give_verdict();
    end
endmodule
